/* peripheral_irq_aggregator.sv */
// peripheral interrupt aggregator: event flags, enables, core interrupt line
`timescale 1ns/100ps
`default_nettype none

module peripheral_irq_aggregator (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             master_clear_n,
  input  wire pia_pkg::pia_req_t port_req,
  output logic [7:0]            port_rdata,
  input  wire pia_pkg::pia_src_t src,
  input  wire logic             detect_pin,
  input  wire logic             supply_above_3v,
  input  wire logic             gauge_charge_dir,
  output logic                  core_peripheral_irq_line
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic pia_changed(input logic prev, input logic cur);
    pia_changed = prev ^ cur;
  endfunction : pia_changed

  function automatic logic pia_hit(input pia_pkg::pia_req_t r,
                                   input logic [7:0]       a);
    pia_hit = (r.addr == a);
  endfunction : pia_hit

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pins and foreign levels

  logic [1:0] master_clear_n_sync;
  logic [1:0] detect_sync;
  logic [1:0] supply_sync;
  logic [1:0] dir_sync;
  logic       detect_last;
  logic       supply_last;
  logic       dir_last;

  // first stage is read only by the second stage and by the detect and direction sampling checks
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      master_clear_n_sync   <= 2'h0;
      detect_sync <= 2'h0;
      supply_sync <= 2'h0;
      dir_sync    <= 2'h0;
    end else begin
      master_clear_n_sync   <= {master_clear_n_sync[0], master_clear_n};
      detect_sync <= {detect_sync[0], detect_pin};
      supply_sync <= {supply_sync[0], supply_above_3v};
      dir_sync    <= {dir_sync[0], gauge_charge_dir};
    end
  end

  // last-seen levels for edge detection
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      detect_last <= 1'b0;
      supply_last <= 1'b0;
      dir_last    <= 1'b0;
    end else begin
      detect_last <= detect_sync[1];
      supply_last <= supply_sync[1];
      dir_last    <= dir_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event vector

  logic [7:0] events;

  // two-wire bus interrupts have no input here; they reach the core apart
  always_comb begin
    events = 8'h00;
    // supply low after reset reads as 0, so the first rise is caught too
    events[pia_pkg::BIT_POWER_FAIL]   = pia_changed(supply_last, supply_sync[1]);
    events[pia_pkg::BIT_DIRECTION]    = pia_changed(dir_last, dir_sync[1]);
    events[pia_pkg::BIT_CONVERSION]   = src.conv_start | src.conv_done;
    events[pia_pkg::BIT_DETECT]       = pia_changed(detect_last, detect_sync[1]);
    events[pia_pkg::BIT_CHARGE_OC]    = src.charge_oc;
    events[pia_pkg::BIT_DISCHARGE_OC] = src.discharge_oc;
    events[pia_pkg::BIT_CHARGE_WRAP]  = src.charge_wrap;
    events[pia_pkg::BIT_DISCH_WRAP]   = src.discharge_wrap;
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag register

  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] next_flags;
  logic [7:0] clear_mask;
  logic       wr_flags;
  logic       wr_enables;

  assign wr_flags   = port_req.wr & pia_hit(port_req, pia_pkg::ADDR_FLAGS);
  assign wr_enables = port_req.wr & pia_hit(port_req, pia_pkg::ADDR_ENABLES);

  always_comb begin
    clear_mask = wr_flags ? port_req.wdata : 8'h00;
    // set after clear so a coincident event survives
    next_flags = (flags & ~clear_mask) | events;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= pia_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable register

  // master clear holds enables at zero for as long as it is low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enables <= pia_pkg::ENABLE_RESET;
    end else if (!master_clear_n_sync[1]) begin
      enables <= pia_pkg::ENABLE_RESET;
    end else if (wr_enables) begin
      enables <= port_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: reads have no side effects on any state

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_rdata <= pia_pkg::UNMAPPED_RD;
    end else if (port_req.rd) begin
      if (pia_hit(port_req, pia_pkg::ADDR_FLAGS)) begin
        port_rdata <= flags;
      end else if (pia_hit(port_req, pia_pkg::ADDR_ENABLES)) begin
        port_rdata <= enables;
      end else begin
        port_rdata <= pia_pkg::UNMAPPED_RD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core interrupt line, registered for a glitch-free output

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_peripheral_irq_line <= 1'b0;
    end else begin
      core_peripheral_irq_line <= |(flags & enables);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_detect_change;
    detect_sync[1] != detect_last;
  endsequence

  sequence s_dir_change;
    dir_sync[1] != dir_last;
  endsequence

  sequence s_flag_read_only;
    port_req.rd && !port_req.wr && pia_hit(port_req, pia_pkg::ADDR_FLAGS) && events == 8'h00;
  endsequence

  sequence s_supply_change;
    supply_sync[1] != supply_last;
  endsequence

  sequence s_quiet_flags;
    events == 8'h00 && !wr_flags;
  endsequence

  sequence s_unmapped_read;
    port_req.rd && !pia_hit(port_req, pia_pkg::ADDR_FLAGS)
      && !pia_hit(port_req, pia_pkg::ADDR_ENABLES);
  endsequence

  // enabled source with the enable word left alone for one more cycle
  sequence s_enabled_event;
    (events & enables) != 8'h00 && !wr_enables && master_clear_n_sync[1];
  endsequence

  // a pin edge reaches the first sync stage two edges before its flag
  sequence s_detect_sampled;
    $changed(detect_sync[0]);
  endsequence

  sequence s_dir_sampled;
    $changed(dir_sync[0]);
  endsequence

  a_event_sets_flag: assert property (
    (events != 8'h00) |=> ((flags & $past(events)) == $past(events)))
    else $error("event did not set its flag");

  a_masked_still_set: assert property (
    (src.charge_oc && !enables[pia_pkg::BIT_CHARGE_OC])
      |=> flags[pia_pkg::BIT_CHARGE_OC])
    else $error("masked source failed to set flag");

  a_flag_read_kept: assert property (
    s_flag_read_only |=> (flags == $past(flags)) ##0 (port_rdata == $past(flags)))
    else $error("flag read altered flags or returned wrong data");

  a_w1c_clears: assert property (
    (wr_flags && port_req.wdata[pia_pkg::BIT_CHARGE_WRAP] && !src.charge_wrap)
      |=> !flags[pia_pkg::BIT_CHARGE_WRAP])
    else $error("write one did not clear flag");

  a_irq_gated: assert property (
    ##1 (core_peripheral_irq_line == |($past(flags) & $past(enables))))
    else $error("core line does not follow enabled flags");

  a_enable_read_kept: assert property (
    (port_req.rd && !port_req.wr && master_clear_n_sync[1]) |=> (enables == $past(enables)))
    else $error("enable read altered enables");

  a_master_clear_n_clears: assert property (
    (!master_clear_n_sync[1]) |=> (enables == 8'h00) ##1 !core_peripheral_irq_line)
    else $error("master clear did not clear enables");

  a_enable_write: assert property (
    (wr_enables && master_clear_n_sync[1]) |=> (enables == $past(port_req.wdata)))
    else $error("enable write not stored");

  a_detect_edge: assert property (
    s_detect_change |=> flags[pia_pkg::BIT_DETECT])
    else $error("detect edge did not set flag");

  a_dir_edge: assert property (
    s_dir_change |=> flags[pia_pkg::BIT_DIRECTION])
    else $error("direction change did not set flag");

  a_zero_keeps: assert property (
    wr_flags |=> ((flags & $past(flags & ~port_req.wdata))
                  == $past(flags & ~port_req.wdata)))
    else $error("writing zero cleared a flag");

  a_set_beats_clear: assert property (
    (wr_flags && ((port_req.wdata & events) != 8'h00))
      |=> ((flags & $past(port_req.wdata & events))
           == $past(port_req.wdata & events)))
    else $error("coincident event lost to clear");

  a_conversion_flag: assert property (
    (src.conv_start || src.conv_done) |=> flags[pia_pkg::BIT_CONVERSION])
    else $error("conversion event did not set flag");

  // one check per flag bit so a swapped position shows up
  a_power_fail_edge: assert property (
    s_supply_change |=> flags[pia_pkg::BIT_POWER_FAIL])
    else $error("supply crossing did not set flag");

  a_charge_oc_flag: assert property (
    src.charge_oc |=> flags[pia_pkg::BIT_CHARGE_OC])
    else $error("charge overcurrent did not set flag");

  a_discharge_oc_flag: assert property (
    src.discharge_oc |=> flags[pia_pkg::BIT_DISCHARGE_OC])
    else $error("discharge overcurrent did not set flag");

  a_charge_wrap_flag: assert property (
    src.charge_wrap |=> flags[pia_pkg::BIT_CHARGE_WRAP])
    else $error("charge wrap did not set flag");

  a_discharge_wrap_flag: assert property (
    src.discharge_wrap |=> flags[pia_pkg::BIT_DISCH_WRAP])
    else $error("discharge wrap did not set flag");

  a_flags_hold: assert property (
    s_quiet_flags |=> $stable(flags))
    else $error("flags changed without event or write");

  a_no_spurious_set: assert property (
    ##1 ((flags & ~$past(flags) & ~$past(events)) == 8'h00))
    else $error("flag set without its event");

  a_flag_read_data: assert property (
    (port_req.rd && pia_hit(port_req, pia_pkg::ADDR_FLAGS))
      |=> (port_rdata == $past(flags)))
    else $error("flag read returned wrong data");

  a_enable_read_data: assert property (
    (port_req.rd && pia_hit(port_req, pia_pkg::ADDR_ENABLES))
      |=> (port_rdata == $past(enables)))
    else $error("enable read returned wrong data");

  a_unmapped_read: assert property (
    s_unmapped_read |=> (port_rdata == pia_pkg::UNMAPPED_RD))
    else $error("unmapped read returned data");

  a_rdata_holds: assert property (
    !port_req.rd |=> $stable(port_rdata))
    else $error("read data changed without a read");

  a_stray_write_enables: assert property (
    (port_req.wr && !wr_enables && master_clear_n_sync[1]) |=> $stable(enables))
    else $error("write elsewhere altered enables");

  a_enables_hold: assert property (
    (!wr_enables && master_clear_n_sync[1]) |=> $stable(enables))
    else $error("enables changed without a write");

  a_irq_off_masked: assert property (
    (enables == 8'h00) |=> !core_peripheral_irq_line)
    else $error("core line raised with all sources masked");

  a_event_to_irq: assert property (
    s_enabled_event |=> ##1 core_peripheral_irq_line)
    else $error("enabled event did not reach core line");

  a_detect_sampled: assert property (
    s_detect_sampled |-> ##2 flags[pia_pkg::BIT_DETECT])
    else $error("detect pin edge late to its flag");

  a_dir_sampled: assert property (
    s_dir_sampled |-> ##2 flags[pia_pkg::BIT_DIRECTION])
    else $error("direction change late to its flag");

endmodule : peripheral_irq_aggregator
`default_nettype wire

/* peripheral_irq_aggregator_tb.sv */
// self-checking bench for the peripheral interrupt aggregator
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_aggregator_tb;
  localparam logic [7:0] FL = pia_pkg::ADDR_FLAGS;
  localparam logic [7:0] EN = pia_pkg::ADDR_ENABLES;
  logic                  ref_clk, sys_rst, master_clear_n, detect_pin;
  logic                  supply_above_3v, gauge_charge_dir, irq;
  logic [7:0]            port_rdata;
  pia_pkg::pia_req_t     port_req;
  pia_pkg::pia_src_t     src;
  int                    n_errors = 0;
  int                    tests_run = 0;

  pia_core_model core (.ref_clk(ref_clk), .port_req(port_req));

  peripheral_irq_aggregator DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .master_clear_n(master_clear_n),
    .port_req(port_req), .port_rdata(port_rdata), .src(src),
    .detect_pin(detect_pin), .supply_above_3v(supply_above_3v),
    .gauge_charge_dir(gauge_charge_dir), .core_peripheral_irq_line(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_irq(input logic exp);
    tests_run++;
    if (irq !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: irq %b expected %b", $time, irq, exp);
    end
  endtask : check_irq

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    core.access(a, 8'h00, 1'b0);
    check(port_rdata, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.access(a, d, 1'b1);
  endtask : wr

  // one event on source i; 8 is the conversion start pulse
  task automatic fire(input int i);
    wait_cyc(1);
    case (i)
      7: supply_above_3v = ~supply_above_3v;
      6: gauge_charge_dir = ~gauge_charge_dir;
      5: src.conv_done = 1'b1;
      4: detect_pin = ~detect_pin;
      3: src.charge_oc = 1'b1;
      2: src.discharge_oc = 1'b1;
      1: src.charge_wrap = 1'b1;
      8: src.conv_start = 1'b1;
      default: src.discharge_wrap = 1'b1;
    endcase
    wait_cyc(1);
    src = '0;
    // pin inputs pass a two-flop synchroniser first
    wait_cyc(5);
  endtask : fire

  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    wait_cyc(5000);
    n_errors++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    master_clear_n = 1'b1;
    detect_pin = 1'b0;
    supply_above_3v = 1'b0;
    gauge_charge_dir = 1'b0;
    src = '0;
    wait_cyc(20);
    sys_rst = 1'b0;
    wait_cyc(3);
    rd(FL, pia_pkg::FLAGS_RESET);
    rd(EN, pia_pkg::ENABLE_RESET);
    wr(EN, 8'hA5);
    rd(EN, 8'hA5);
    rd(EN, 8'hA5);
    wr(8'h10, 8'hFF);
    rd(8'h10, pia_pkg::UNMAPPED_RD);
    rd(EN, 8'hA5);
    wr(EN, 8'h00);
    for (int i = 0; i <= 8; i++) fire(i);
    rd(FL, 8'hFF);
    rd(FL, 8'hFF);
    check_irq(1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(FL, 8'hFF);
      rd(FL, 8'h00);
      wr(EN, 8'h01 << i);
      fire(i);
      rd(FL, 8'h01 << i);
      check_irq(1'b1);
      wr(FL, ~(8'h01 << i));
      rd(FL, 8'h01 << i);
      wr(FL, 8'h01 << i);
      wait_cyc(2);
      check_irq(1'b0);
    end
    wr(FL, 8'hFF);
    // clear and event land on the same edge
    fork
      wr(FL, 8'h02);
      begin
        wait_cyc(1);
        src.charge_wrap = 1'b1;
        wait_cyc(1);
        src = '0;
      end
    join
    rd(FL, 8'h02);
    wr(EN, 8'hFF);
    master_clear_n = 1'b0;
    wait_cyc(4);
    rd(EN, 8'h00);
    wr(EN, 8'hFF);
    rd(EN, 8'h00);
    master_clear_n = 1'b1;
    wait_cyc(4);
    rd(EN, 8'h00);
    rd(FL, 8'h02);
    check_irq(1'b0);
    // second power-on reset in mid-run with a live line
    wr(EN, 8'hFF);
    wait_cyc(1);
    check_irq(1'b1);
    sys_rst = 1'b1;
    wait_cyc(2);
    sys_rst = 1'b0;
    wait_cyc(3);
    rd(EN, pia_pkg::ENABLE_RESET);
    rd(FL, pia_pkg::FLAGS_RESET);
    check_irq(1'b0);
    finish_test();
  end

endmodule : peripheral_irq_aggregator_tb
`default_nettype wire

/* pia_core_model.sv */
// core-side model that issues register port requests to the aggregator
`timescale 1ns/100ps
`default_nettype none
module pia_core_model (
  input  wire logic             ref_clk,
  output var pia_pkg::pia_req_t port_req
);

  initial port_req = '0;

  // request held from just after one edge through the taking edge, then dropped
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk);
    #1;
    port_req = {a, d, w, ~w};
    @(posedge ref_clk);
    #1;
    port_req = '0;
  endtask : access

endmodule : pia_core_model
`default_nettype wire

/* pia_pkg.sv */
// constants and carrier types for the peripheral interrupt aggregator
`default_nettype none
package pia_pkg;

  localparam int unsigned     DATA_W       = 8;
  localparam int unsigned     ADDR_W       = 8;
  localparam int unsigned     SRC_COUNT    = 8;
  localparam int unsigned     SYNC_STAGES  = 2;

  // register port addresses
  localparam logic [7:0]      ADDR_FLAGS   = 8'h0E;
  localparam logic [7:0]      ADDR_ENABLES = 8'h0F;

  // reset values
  localparam logic [7:0]      FLAGS_RESET  = 8'h00;
  localparam logic [7:0]      ENABLE_RESET = 8'h00;
  localparam logic [7:0]      UNMAPPED_RD  = 8'h00;

  // flag and enable bit positions (enables mirror flags)
  localparam int unsigned     BIT_POWER_FAIL   = 7;
  localparam int unsigned     BIT_DIRECTION    = 6;
  localparam int unsigned     BIT_CONVERSION   = 5;
  localparam int unsigned     BIT_DETECT       = 4;
  localparam int unsigned     BIT_CHARGE_OC    = 3;
  localparam int unsigned     BIT_DISCHARGE_OC = 2;
  localparam int unsigned     BIT_CHARGE_WRAP  = 1;
  localparam int unsigned     BIT_DISCH_WRAP   = 0;

  // one-cycle event pulses from peripherals on ref_clk
  typedef struct packed {
    logic conv_start;
    logic conv_done;
    logic charge_oc;
    logic discharge_oc;
    logic charge_wrap;
    logic discharge_wrap;
  } pia_src_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pia_req_t;

endpackage : pia_pkg
`default_nettype wire
